// ===== inc/msel_pkg.sv
/*
  Shared constants and types of the operating-mode selector: register
  offsets and fields, reset values, diagnostic words, state encoding and
  the structs that carry the APB bus and the selector outputs.
  Assumes a 32-bit APB bus with byte addresses and a single 50 MHz clock.
*/
package msel_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TIMEOUT = 8'h04;
  localparam logic [7:0] OFF_DIAG = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_MASK = 8'h10;
  localparam int CTRL_ACTIVATE_BIT = 0;
  localparam int CTRL_AUTO_BIT = 1;
  localparam int STAT_ERR_BIT = 0;
  localparam int STAT_VALID_BIT = 1;
  localparam int STAT_AWAIT_BIT = 2;
  localparam int STAT_W = 3;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [31:0] TIMEOUT_RST = 32'h0000C350;
  localparam logic [STAT_W-1:0] MASK_RST = 3'h0;
  localparam logic [31:0] COUNT_MAX = 32'hFFFFFFFF;

  // ----------------------------------------------------------------
  // Diagnostic words
  // ----------------------------------------------------------------
  localparam logic [15:0] DIAG_IDLE = 16'h0000;
  localparam logic [15:0] DIAG_AWAIT = 16'h8802;
  localparam logic [15:0] DIAG_VALID = 16'h8000;
  localparam logic [15:0] DIAG_FROZEN = 16'h8010;
  localparam logic [15:0] DIAG_SC_ACK = 16'hC410;
  localparam logic [15:0] DIAG_SC_NACK = 16'hC010;
  localparam logic [15:0] DIAG_OC_ACK = 16'hC420;
  localparam logic [15:0] DIAG_OC_NACK = 16'hC020;
  localparam logic [15:0] DIAG_RST1 = 16'hC011;
  localparam logic [15:0] DIAG_RST2 = 16'hC021;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_AWAIT = 4'h1,
    ST_VALID = 4'h2,
    ST_FROZEN = 4'h3,
    ST_SC_ACK = 4'h4,
    ST_SC_NACK = 4'h5,
    ST_OC_ACK = 4'h6,
    ST_OC_NACK = 4'h7,
    ST_RST1 = 4'h8,
    ST_RST2 = 4'h9
  } msel_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } msel_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } msel_apb_rsp_t;

  typedef struct packed {
    logic [15:0] diagnosticWord;
    logic [7:0] modeChosen;
    logic anyModeChosen;
    logic ready;
    logic protectiveRequest;
    logic ackWanted;
    logic error;
  } msel_out_t;

endpackage : msel_pkg

// ===== src/msel_monitor.sv
/*
  Absent-choice monitor: counts clock cycles while no mode request is
  active, restarting on every falling request and whenever monitoring
  is off. Assumes requests are synchronous to ref_clk.
*/
`timescale 1ns/1ns
module msel_monitor (
  input logic ref_clk,
  input logic rst_n,
  input logic clkEn,
  input logic run,
  input logic [7:0] modeRequest,
  input logic [31:0] limit,
  output logic expired
);
  import msel_pkg::*;

  logic [7:0] reqPrev_r;
  logic [31:0] cnt_r;
  logic [31:0] cntNxt;
  logic expired_r;
  logic fallSeen;
  logic noneActive;

  // ----------------------------------------------------------------
  // Counter control
  // ----------------------------------------------------------------
  // The count saturates so that a very long gap cannot wrap and hide.
  assign fallSeen = |(reqPrev_r & ~modeRequest);
  assign noneActive = (modeRequest == 8'h00);
  assign cntNxt = (!run || fallSeen || !noneActive) ? 32'h00000000 :
                  (cnt_r == COUNT_MAX) ? cnt_r : cnt_r + 32'h00000001;
  assign expired = expired_r;

  // Counter and flag registers.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reqPrev_r <= 8'h00;
      cnt_r <= 32'h00000000;
      expired_r <= 1'b0;
    end else if (clkEn) begin
      reqPrev_r <= modeRequest;
      cnt_r <= cntNxt;
      expired_r <= run && noneActive && !fallSeen && (cnt_r > limit);
    end
  end

endmodule : msel_monitor

// ===== src/msel_mode_selector.sv
/*
  Operating-mode selector with error handling and an APB register file.
  Eight one-hot mode requests are accepted, frozen and reported; short and
  open faults drive the error states. Assumes all pins are synchronous to
  ref_clk and that the APB master follows the usual two-phase protocol.
*/
// Function
// - Any error state forces selects and any-mode low, error high, code shown.
// - A rising acknowledge edge moves an acknowledgeable error state to awaiting-accept.
// - Two or more requests at once enter the short-circuit family immediately.
// - Short fault is acknowledgeable with one or no request, else not.
// - Ack-wanted is inverse acknowledge in ack states, low otherwise; ready high.
// - No request for longer than the timeout enters the open-circuit family.
// - Open fault is acknowledgeable with exactly one request, else not.
// - Acknowledge held high in acknowledgeable short state enters reset-error one.
// - Acknowledge held high in acknowledgeable open state enters reset-error two.
// - Inactive state shows zero code and all outputs low.
// - Awaiting-accept drives ready and protective request high, others low.
// - Valid selection drives ready, any-mode and the chosen select high.
// - Frozen selection keeps chosen select, any-mode and ready high.
// - Deactivation returns to inactive from any state with top priority.
// - Acceptance needs exactly one request and a trigger unless automatic.
// - A new request without hold-release returns valid to awaiting-accept.
// - The diagnostic word is 16 bits and resets to zero.
`timescale 1ns/1ns
module msel_mode_selector (
  input logic ref_clk,
  input logic rst_n,
  input logic clkEn,
  input msel_pkg::msel_apb_req_t apbReq,
  output msel_pkg::msel_apb_rsp_t apbRsp,
  input logic [7:0] modeRequest,
  input logic acceptTrigger,
  input logic errAck,
  input logic holdRelease,
  input logic freezeReq,
  output msel_pkg::msel_out_t selOut,
  output logic irq
);
  import msel_pkg::*;

  msel_state_t state_r;
  msel_state_t stateNxt;
  logic [7:0] chosen_r;
  logic [7:0] chosenNxt;
  logic ackPrev_r;
  logic acceptPrev_r;
  logic [1:0] ctrl_r;
  logic [31:0] timeout_r;
  logic [STAT_W-1:0] status_r;
  logic [STAT_W-1:0] statusNxt;
  logic [STAT_W-1:0] mask_r;
  msel_apb_rsp_t rsp_r;
  msel_out_t out_r;
  msel_out_t outNxt;
  logic irq_r;

  // ----------------------------------------------------------------
  // Input decode
  // ----------------------------------------------------------------
  // Clearing the lowest set bit leaves something only if two are set.
  logic reqMulti;
  logic reqOne;
  logic reqNone;
  logic ackRise;
  logic ackStatic;
  logic acceptRise;
  logic ctrlActive;
  logic ctrlAuto;
  logic monRun;
  logic openExpired;
  assign reqMulti = |(modeRequest & (modeRequest - 8'h01));
  assign reqNone = (modeRequest == 8'h00);
  assign reqOne = !reqNone && !reqMulti;
  assign ackRise = errAck && !ackPrev_r;
  assign ackStatic = errAck && ackPrev_r;
  assign acceptRise = acceptTrigger && !acceptPrev_r;
  assign ctrlActive = ctrl_r[CTRL_ACTIVATE_BIT];
  assign ctrlAuto = ctrl_r[CTRL_AUTO_BIT];
  assign monRun = (state_r == ST_AWAIT) || (state_r == ST_VALID) ||
                  (state_r == ST_FROZEN);

  // The monitor restarts whenever the normal states are left, so the
  // timeout always begins again after activation or an acknowledge.
  msel_monitor u_monitor (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .run(monRun),
    .modeRequest(modeRequest),
    .limit(timeout_r),
    .expired(openExpired)
  );

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  // Next state; deactivation outranks every other transition.
  always_comb begin
    stateNxt = state_r;
    chosenNxt = chosen_r;
    if (!ctrlActive) begin
      stateNxt = ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          stateNxt = ST_AWAIT;
        end
        ST_AWAIT, ST_VALID, ST_FROZEN: begin
          if (reqMulti) begin
            stateNxt = ST_SC_NACK;
          end else if (openExpired && reqNone) begin
            stateNxt = ST_OC_NACK;
          end else if (state_r == ST_AWAIT) begin
            if (reqOne && (ctrlAuto || acceptRise)) begin
              stateNxt = ST_VALID;
              chosenNxt = modeRequest;
            end
          end else if (state_r == ST_VALID) begin
            if ((modeRequest != chosen_r) && !holdRelease) begin
              stateNxt = ST_AWAIT;
            end else if (freezeReq) begin
              stateNxt = ST_FROZEN;
            end
          end else if (!freezeReq) begin
            stateNxt = ST_VALID;
          end
        end
        ST_SC_ACK: begin
          if (reqMulti) begin
            stateNxt = ST_SC_NACK;
          end else if (ackStatic) begin
            stateNxt = ST_RST1;
          end else if (ackRise) begin
            stateNxt = ST_AWAIT;
          end
        end
        ST_SC_NACK: begin
          if (!reqMulti) begin
            stateNxt = ST_SC_ACK;
          end
        end
        ST_OC_ACK: begin
          if (!reqOne) begin
            stateNxt = ST_OC_NACK;
          end else if (ackStatic) begin
            stateNxt = ST_RST2;
          end else if (ackRise) begin
            stateNxt = ST_AWAIT;
          end
        end
        ST_OC_NACK: begin
          if (reqOne) begin
            stateNxt = ST_OC_ACK;
          end
        end
        ST_RST1: begin
          if (!errAck) begin
            stateNxt = ST_SC_ACK;
          end
        end
        ST_RST2: begin
          if (!errAck) begin
            stateNxt = ST_OC_ACK;
          end
        end
        default: begin
          stateNxt = ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output decode
  // ----------------------------------------------------------------
  // Outputs are decoded from the next state and registered, so they
  // always agree with state_r in the same cycle.
  logic nxtErr;
  logic nxtAckState;
  logic nxtChosen;
  logic [15:0] diagNxt;
  assign nxtAckState = (stateNxt == ST_SC_ACK) || (stateNxt == ST_OC_ACK);
  assign nxtErr = (stateNxt >= ST_SC_ACK);
  assign nxtChosen = (stateNxt == ST_VALID) || (stateNxt == ST_FROZEN);

  // Diagnostic word per state.
  always_comb begin
    case (stateNxt)
      ST_IDLE: diagNxt = DIAG_IDLE;
      ST_AWAIT: diagNxt = DIAG_AWAIT;
      ST_VALID: diagNxt = DIAG_VALID;
      ST_FROZEN: diagNxt = DIAG_FROZEN;
      ST_SC_ACK: diagNxt = DIAG_SC_ACK;
      ST_SC_NACK: diagNxt = DIAG_SC_NACK;
      ST_OC_ACK: diagNxt = DIAG_OC_ACK;
      ST_OC_NACK: diagNxt = DIAG_OC_NACK;
      ST_RST1: diagNxt = DIAG_RST1;
      ST_RST2: diagNxt = DIAG_RST2;
      default: diagNxt = DIAG_IDLE;
    endcase
  end

  // Flag outputs; error states never show a select.
  assign outNxt.diagnosticWord = diagNxt;
  assign outNxt.modeChosen = nxtChosen ? chosenNxt : 8'h00;
  assign outNxt.anyModeChosen = nxtChosen;
  assign outNxt.ready = (stateNxt != ST_IDLE);
  assign outNxt.protectiveRequest = (stateNxt == ST_AWAIT);
  assign outNxt.ackWanted = nxtAckState && !errAck;
  assign outNxt.error = nxtErr;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // No wait state: read data are captured in the setup cycle and pready
  // rises in the first access cycle.
  logic setupPhase;
  logic accessDone;
  logic hitCtrl;
  logic hitTimeout;
  logic hitDiag;
  logic hitStatus;
  logic hitMask;
  logic mapped;
  logic wrDone;
  logic rdStatus;
  logic [31:0] rdMux;
  assign setupPhase = apbReq.psel && !apbReq.penable;
  assign accessDone = apbReq.psel && apbReq.penable && rsp_r.pready;
  assign hitCtrl = (apbReq.paddr == OFF_CTRL);
  assign hitTimeout = (apbReq.paddr == OFF_TIMEOUT);
  assign hitDiag = (apbReq.paddr == OFF_DIAG);
  assign hitStatus = (apbReq.paddr == OFF_STATUS);
  assign hitMask = (apbReq.paddr == OFF_MASK);
  assign mapped = hitCtrl || hitTimeout || hitDiag || hitStatus || hitMask;
  assign wrDone = accessDone && apbReq.pwrite;
  assign rdStatus = accessDone && !apbReq.pwrite && hitStatus;
  assign rdMux = hitCtrl ? {30'h00000000, ctrl_r} :
                 hitTimeout ? timeout_r :
                 hitDiag ? {12'h000, state_r, out_r.diagnosticWord} :
                 hitStatus ? {29'h00000000, status_r} :
                 hitMask ? {29'h00000000, mask_r} : 32'h00000000;

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  // A read clears the status, but an event in the same cycle still sets.
  logic [STAT_W-1:0] events;
  assign events[STAT_ERR_BIT] = nxtErr && (state_r < ST_SC_ACK);
  assign events[STAT_VALID_BIT] = (stateNxt == ST_VALID) && (state_r != ST_VALID);
  assign events[STAT_AWAIT_BIT] = (stateNxt == ST_AWAIT) && (state_r != ST_AWAIT);
  assign statusNxt = (rdStatus ? {STAT_W{1'b0}} : status_r) | events;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Core state and edge detectors; clkEn low freezes everything.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      chosen_r <= 8'h00;
      ackPrev_r <= 1'b0;
      acceptPrev_r <= 1'b0;
      out_r <= '0;
      irq_r <= 1'b0;
      status_r <= {STAT_W{1'b0}};
    end else if (clkEn) begin
      state_r <= stateNxt;
      chosen_r <= chosenNxt;
      ackPrev_r <= errAck;
      acceptPrev_r <= acceptTrigger;
      out_r <= outNxt;
      status_r <= statusNxt;
      irq_r <= |(statusNxt & mask_r);
    end
  end

  // Software registers and bus answer.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RST;
      timeout_r <= TIMEOUT_RST;
      mask_r <= MASK_RST;
      rsp_r <= '0;
    end else if (clkEn) begin
      rsp_r.pready <= setupPhase;
      rsp_r.pslverr <= setupPhase && !mapped;
      rsp_r.prdata <= setupPhase ? rdMux : rsp_r.prdata;
      if (wrDone && hitCtrl) begin
        ctrl_r <= apbReq.pwdata[1:0];
      end
      if (wrDone && hitTimeout) begin
        timeout_r <= apbReq.pwdata;
      end
      if (wrDone && hitMask) begin
        mask_r <= apbReq.pwdata[STAT_W-1:0];
      end
    end
  end

  assign apbRsp = rsp_r;
  assign selOut = out_r;
  assign irq = irq_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_step;
    clkEn && ctrlActive;
  endsequence
  sequence s_normal;
    (state_r == ST_AWAIT) || (state_r == ST_VALID) || (state_r == ST_FROZEN);
  endsequence

  a_error_safe_outs: assert property (
    out_r.error |-> (out_r.modeChosen == 8'h00) && !out_r.anyModeChosen &&
      out_r.diagnosticWord[15:12] == 4'hC)
    else $error("Error state shows a mode select.");
  a_ack_leaves: assert property (
    s_step ##0 (state_r == ST_SC_ACK && !reqMulti && ackRise) |=> state_r == ST_AWAIT)
    else $error("Acknowledge edge did not leave the error state.");
  a_short_detect: assert property (
    s_step ##0 s_normal ##0 reqMulti |=> out_r.diagnosticWord == DIAG_SC_NACK)
    else $error("Short fault not detected at once.");
  a_short_code: assert property (
    (state_r == ST_SC_NACK) ##0 s_step ##0 !reqMulti
      |=> out_r.diagnosticWord == DIAG_SC_ACK)
    else $error("Short fault code did not follow the requests.");
  a_ack_wanted: assert property (
    clkEn && ctrlActive && (state_r == ST_OC_ACK) && reqOne && !errAck
      |=> out_r.ackWanted && out_r.ready && !out_r.protectiveRequest)
    else $error("Ack-wanted wrong in an acknowledgeable state.");
  a_open_detect: assert property (
    s_step ##0 s_normal ##0 (openExpired && reqNone)
      |=> out_r.diagnosticWord == DIAG_OC_NACK && out_r.error)
    else $error("Open fault not detected after the timeout.");
  a_static_short: assert property (
    s_step ##0 (state_r == ST_SC_ACK && !reqMulti && ackStatic)
      |=> out_r.diagnosticWord == DIAG_RST1 && !out_r.ackWanted)
    else $error("Static acknowledge in short state not caught.");
  a_static_open: assert property (
    s_step ##0 (state_r == ST_OC_ACK && reqOne && ackStatic)
      |=> out_r.diagnosticWord == DIAG_RST2 && out_r.error)
    else $error("Static acknowledge in open state not caught.");
  a_idle_quiet: assert property (
    (state_r == ST_IDLE) |-> (out_r == '0))
    else $error("Inactive state drives an output.");
  a_await_outs: assert property (
    (state_r == ST_AWAIT) |-> out_r.ready && out_r.protectiveRequest &&
      !out_r.error && out_r.diagnosticWord == DIAG_AWAIT)
    else $error("Awaiting-accept outputs wrong.");
  a_valid_outs: assert property (
    (state_r == ST_VALID) |-> $onehot(out_r.modeChosen) && out_r.anyModeChosen &&
      out_r.modeChosen == chosen_r && !out_r.protectiveRequest)
    else $error("Valid selection outputs wrong.");
  a_deactivate: assert property (
    clkEn && !ctrlActive |=> state_r == ST_IDLE && out_r.diagnosticWord == DIAG_IDLE)
    else $error("Deactivation did not return to inactive.");
  a_accept_gate: assert property (
    s_step ##0 (state_r == ST_AWAIT) && reqNone |=> state_r != ST_VALID)
    else $error("Accepted with no request active.");
  a_reset_err_exit: assert property (
    s_step ##0 (state_r == ST_RST1) && !errAck |=> state_r == ST_SC_ACK)
    else $error("Reset-error state did not return when acknowledge fell.");

endmodule : msel_mode_selector

// ===== test/msel_switch_model.sv
/*
  Model of the mode selector switch and the operator push buttons.
  Assumes the bench changes its commands just after a rising edge of ref_clk.
*/
`timescale 1ns/1ns
module msel_switch_model (
  input wire logic ref_clk,
  input wire logic slow,
  input wire logic [7:0] posCmd,
  input wire logic [3:0] btnCmd,
  output logic [7:0] modeRequest,
  output logic acceptTrigger,
  output logic errAck,
  output logic holdRelease,
  output logic freezeReq
);
  // ----------------------------------------------------------------
  // Contact settling
  // ----------------------------------------------------------------
  logic [11:0] stage_r = 12'h000;
  logic [11:0] late_r = 12'h000;

  // Contacts settle one edge late, or two when slow, like a worn switch.
  always_ff @(posedge ref_clk) begin
    stage_r <= {posCmd, btnCmd};
    late_r <= stage_r;
  end

  // The acknowledge button makes clean rising and falling edges here.
  assign {modeRequest, acceptTrigger, errAck, holdRelease, freezeReq} = slow ? late_r : stage_r;
endmodule : msel_switch_model

// ===== test/msel_mode_selector_test.sv
/*
  Self-checking bench of the mode selector: APB access, switch model, states.
  Assumes one 50 MHz clock and pready within a few cycles of setup.
*/
`timescale 1ns/1ns
module msel_mode_selector_test;
  import msel_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clkEn = 1'b1;
  logic slow = 1'b0;
  logic [7:0] posCmd = 8'h00;
  logic [3:0] btnCmd = 4'h0;
  msel_apb_req_t apbReq = '0;
  msel_apb_rsp_t apbRsp;
  msel_out_t selOut;
  logic irq;
  logic [7:0] modeRequest;
  logic acceptTrigger, errAck, holdRelease, freezeReq;
  logic [31:0] rd;
  logic err;
  int failures = 0;
  int comparisons = 0;

  always #10 ref_clk = ~ref_clk;

  msel_switch_model operator (.ref_clk(ref_clk), .slow(slow), .posCmd(posCmd),
    .btnCmd(btnCmd), .modeRequest(modeRequest), .acceptTrigger(acceptTrigger),
    .errAck(errAck), .holdRelease(holdRelease), .freezeReq(freezeReq));

  msel_mode_selector uut (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn),
    .apbReq(apbReq), .apbRsp(apbRsp), .modeRequest(modeRequest),
    .acceptTrigger(acceptTrigger), .errAck(errAck), .holdRelease(holdRelease),
    .freezeReq(freezeReq), .selOut(selOut), .irq(irq));

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  // One APB transfer; the request is held until pready is seen at an edge.
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge ref_clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
    @(posedge ref_clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 50);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    if (n >= 50) begin
      failures++;
      $display("ERROR %0t no pready", $time);
    end
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask : apb

  task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask : checkVal

  // Expected pin picture of a state, worked out from its diagnostic word.
  function automatic msel_out_t expOut(input logic [15:0] code, input logic [7:0] ch,
                                       input logic ackIn);
    msel_out_t e;
    e = '0;
    e.diagnosticWord = code;
    e.ready = (code != DIAG_IDLE);
    e.error = (code[15:14] == 2'b11);
    e.protectiveRequest = (code == DIAG_AWAIT);
    e.ackWanted = (code == DIAG_SC_ACK || code == DIAG_OC_ACK) && !ackIn;
    if (code == DIAG_VALID || code == DIAG_FROZEN) begin
      e.modeChosen = ch;
      e.anyModeChosen = 1'b1;
    end
    return e;
  endfunction : expOut

  // Waits, bounded, for a diagnostic word, then compares every output.
  task automatic expectState(input logic [15:0] code, input logic [7:0] ch);
    int n;
    n = 0;
    while (selOut.diagnosticWord !== code && n < 40) begin
      @(posedge ref_clk);
      n++;
    end
    comparisons++;
    if (selOut !== expOut(code, ch, errAck)) begin
      failures++;
      $display("ERROR %0t outputs %h expected %h", $time, selOut, expOut(code, ch, errAck));
    end
  endtask : expectState

  task automatic drive(input logic [7:0] p, input logic [3:0] b);
    @(posedge ref_clk);
    posCmd <= p;
    btnCmd <= b;
  endtask : drive

  task automatic give_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  // Button word is {trigger, acknowledge, hold-release, freeze}.
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    expectState(DIAG_IDLE, 8'h00);
    apb(1'b0, OFF_CTRL, 32'h0);
    checkVal(rd, {30'h0, CTRL_RST});
    apb(1'b0, OFF_TIMEOUT, 32'h0);
    checkVal(rd, TIMEOUT_RST);
    apb(1'b0, 8'h20, 32'h0);
    checkVal({31'h0, err}, 32'h1);
    $display("test reset done");
    // A short timeout keeps the open-circuit wait brief.
    apb(1'b1, OFF_TIMEOUT, 32'h0000000A);
    apb(1'b0, OFF_STATUS, 32'h0);
    apb(1'b1, OFF_MASK, 32'h1);
    apb(1'b1, OFF_CTRL, 32'h1);
    expectState(DIAG_AWAIT, 8'h00);
    checkVal({31'h0, irq}, 32'h0);
    drive(8'h00, 4'h8);
    drive(8'h00, 4'h0);
    repeat (3) @(posedge ref_clk);
    expectState(DIAG_AWAIT, 8'h00);
    drive(8'h04, 4'h0);
    drive(8'h04, 4'h8);
    expectState(DIAG_VALID, 8'h04);
    drive(8'h04, 4'h1);
    expectState(DIAG_FROZEN, 8'h04);
    drive(8'h04, 4'h0);
    expectState(DIAG_VALID, 8'h04);
    drive(8'h08, 4'h0);
    expectState(DIAG_AWAIT, 8'h00);
    $display("test selection done");
    slow <= 1'b1;
    drive(8'h18, 4'h0);
    expectState(DIAG_SC_NACK, 8'h00);
    repeat (3) @(posedge ref_clk);
    checkVal({31'h0, irq}, 32'h1);
    apb(1'b0, OFF_STATUS, 32'h0);
    checkVal(rd & 32'h1, 32'h1);
    repeat (3) @(posedge ref_clk);
    checkVal({31'h0, irq}, 32'h0);
    drive(8'h18, 4'h4);
    repeat (4) @(posedge ref_clk);
    expectState(DIAG_SC_NACK, 8'h00);
    drive(8'h10, 4'h4);
    expectState(DIAG_RST1, 8'h00);
    drive(8'h10, 4'h0);
    expectState(DIAG_SC_ACK, 8'h00);
    drive(8'h10, 4'h4);
    expectState(DIAG_AWAIT, 8'h00);
    slow <= 1'b0;
    drive(8'h00, 4'h0);
    $display("test short circuit done");
    expectState(DIAG_OC_NACK, 8'h00);
    drive(8'h00, 4'h4);
    drive(8'h02, 4'h4);
    expectState(DIAG_RST2, 8'h00);
    drive(8'h02, 4'h0);
    expectState(DIAG_OC_ACK, 8'h00);
    drive(8'h02, 4'h4);
    expectState(DIAG_AWAIT, 8'h00);
    drive(8'h02, 4'h0);
    $display("test open circuit done");
    apb(1'b1, OFF_CTRL, 32'h0);
    expectState(DIAG_IDLE, 8'h00);
    apb(1'b1, OFF_CTRL, 32'h3);
    expectState(DIAG_VALID, 8'h02);
    apb(1'b0, OFF_DIAG, 32'h0);
    checkVal({16'h0, rd[15:0]}, {16'h0, DIAG_VALID});
    $display("test enable done");
    // Clock enable low must freeze the block while the switch moves.
    @(posedge ref_clk);
    clkEn <= 1'b0;
    drive(8'h04, 4'h0);
    repeat (4) @(posedge ref_clk);
    expectState(DIAG_VALID, 8'h02);
    clkEn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    expectState(DIAG_VALID, 8'h04);
    // With hold-release set, a changed request must not leave valid selection.
    drive(8'h08, 4'h2);
    repeat (4) @(posedge ref_clk);
    expectState(DIAG_VALID, 8'h04);
    $display("test hold done");
    give_verdict();
  end

  // Whole run needs well under two thousand cycles.
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    $display("ERROR %0t run hung", $time);
    give_verdict();
  end
endmodule : msel_mode_selector_test
